// file: verilog/brt_block_rx.sv
// block receive formatter and transmit acknowledge tracker
// assumes the link receiver and transmitter run on clk_i and present
// decoded header fields under valid/ready, transmit done as a one-cycle strobe; host uses wishbone
// Function
// - accept four block packet kinds for host
// - token with reception status comes first
// - quadlet two: destination id, then control bits
// - requests: source id, 48-bit aligned offset
// - responses: source id plus rcode, reserved fourth
// - quadlet five: length, extended tcode, then data
// - complete flag set only on final block
// - speed code 00/01/10, 11 undefined
// - token quadlet count gives data quadlets
// - token carries five-bit returned ack code
// - destination is bus ten bits, node six
// - retry code new, x, a, b
// - response codes 0,4..7 defined, others reserved
// - keep acks of six latest transmitted packets
// - one 32-bit word per tracking entry
// - readout advances after both halves read
// - bits 4-7 ack code, bit 8 error
// - ack from receiver, or local on failure
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module brt_block_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // received packet header from the link receiver
  input wire logic hdr_valid_i,
  output logic hdr_ready_o,
  input wire logic [3:0] hdr_tcode_i,
  input wire logic [15:0] hdr_dest_id_i,
  input wire logic [5:0] hdr_tlabel_i,
  input wire logic [1:0] hdr_rt_i,
  input wire logic [3:0] hdr_priority_i,
  input wire logic [15:0] hdr_src_id_i,
  input wire logic [47:0] hdr_offset_i,
  input wire logic [3:0] hdr_rcode_i,
  input wire logic [15:0] hdr_data_length_i,
  input wire logic [15:0] hdr_ext_tcode_i,
  input wire logic [1:0] hdr_speed_i,
  input wire logic [4:0] hdr_returned_ack_code_i,
  input wire logic [brt_pkg::QCNT_W-1:0] hdr_quadlet_count_i,
  input wire logic hdr_last_block_i,
  // payload quadlets of the current block
  input wire logic pay_valid_i,
  output logic pay_ready_o,
  input wire logic [31:0] pay_data_i,
  // transmit completion from the link transmitter
  input wire logic tx_done_i,
  input wire logic tx_fail_i,
  input wire logic [4:0] tx_remote_ack_i,
  input wire logic [4:0] tx_local_ack_i,
  input wire logic [5:0] tx_dest_node_i,
  input wire logic [5:0] tx_tlabel_i,
  input wire logic [1:0] tx_rt_i,
  input wire logic [3:0] tx_tcode_i
);
  import brt_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic ack; // wishbone ack
    logic [31:0] rdat; // wishbone read data
    logic irq; // interrupt level
    logic hdr_rdy; // header port ready
    logic pay_rdy; // payload port ready
    brt_state_e st; // formatter state
    logic [3:0] tcode; // latched header fields
    logic [15:0] dest;
    logic [5:0] tlabel;
    logic [1:0] rt;
    logic [3:0] pri;
    logic [15:0] src;
    logic [47:0] offs;
    logic [3:0] rcode;
    logic [15:0] dlen;
    logic [15:0] xtc;
    logic [QCNT_W-1:0] remain; // payload quadlets still to fetch
    logic [31:0] word; // quadlet offered to the host
    logic have; // word is valid
    logic [ACK_DEPTH-1:0][31:0] abuf; // tracking entries
    logic [2:0] wptr; // next slot to write
    logic [2:0] rptr; // oldest entry
    logic [2:0] cnt; // entries held
    logic hi_seen; // upper half of readout read
    logic lo_seen; // lower half of readout read
    logic [NUM_EV-1:0] stat; // sticky events
    logic [NUM_EV-1:0] mask; // interrupt enables
    logic [1:0] ctrl; // enables
  } brt_s;

  brt_s r_reg;
  brt_s r_next;

  // slot pointer step with wrap at the buffer depth
  function automatic logic [2:0] step(input logic [2:0] p);
    step = (p == ACK_DEPTH_C - 3'h1) ? 3'h0 : p + 3'h1;
  endfunction : step

  // per-cycle decodes and strobes
  logic is_resp; // response packet
  logic supported; // one of the four block kinds
  logic take; // wishbone request taken this cycle
  logic rd_grq; // host pops the queue
  logic rd_ack; // host reads the tracking readout
  logic push; // new tracking entry
  logic pop; // readout advances
  logic hdr_take; // header accepted
  logic [31:0] entry; // tracking word built from transmit side
  logic [4:0] ack_sel; // chosen acknowledge
  logic [NUM_EV-1:0] ev; // events this cycle

  // ==========================================================
  // combinational next state
  always_comb begin
    r_next = r_reg;
    is_resp = (r_reg.tcode == TC_WR_RESP) || (r_reg.tcode == TC_RD_BRESP);
    supported = (hdr_tcode_i == TC_WR_BLOCK) || (hdr_tcode_i == TC_RD_BLOCK) ||
                (hdr_tcode_i == TC_WR_RESP) || (hdr_tcode_i == TC_RD_BRESP);
    take = wb_cyc_i && wb_stb_i && !r_reg.ack;
    rd_grq = take && !wb_we_i && (wb_adr_i == ADR_GRQ_DATA) && r_reg.have;
    rd_ack = take && !wb_we_i && (wb_adr_i == ADR_ACK_READOUT);
    hdr_take = hdr_valid_i && r_reg.hdr_rdy;
    ev = '0;
    // ack code from the far node on success, from our transmitter on failure
    ack_sel = tx_fail_i ? tx_local_ack_i : tx_remote_ack_i;
    // node, label, retry, tcode, ack error bit and code
    entry = {tx_dest_node_i, tx_tlabel_i, tx_rt_i, tx_tcode_i, 3'h0, 2'h0,
             ack_sel, 4'h0};
    push = tx_done_i && r_reg.ctrl[CTRL_TRK_EN];
    pop = 1'b0;

    // wishbone: ack one cycle after a request, dropped the cycle after
    r_next.ack = take;
    if (take) begin
      r_next.rdat = 32'h0; // unmapped addresses read zero
      if (!wb_we_i) begin
        case (wb_adr_i)
          ADR_ACK_READOUT: begin
            if (r_reg.cnt != 3'h0) begin
              r_next.rdat = r_reg.abuf[r_reg.rptr];
              r_next.rdat[13:11] = r_reg.cnt; // entries held incl. this one
            end
          end
          ADR_GRQ_DATA: r_next.rdat = r_reg.have ? r_reg.word : 32'h0;
          ADR_STATUS: r_next.rdat = {24'h0, 1'b0, r_reg.cnt, 1'b0, r_reg.st};
          ADR_INT_STATUS: r_next.rdat = {28'h0, r_reg.stat};
          ADR_INT_MASK: r_next.rdat = {28'h0, r_reg.mask};
          ADR_CTRL: r_next.rdat = {30'h0, r_reg.ctrl};
          default: r_next.rdat = 32'h0;
        endcase
      end else begin
        // writes land in the low byte only
        if (wb_sel_i[0]) begin
          case (wb_adr_i)
            ADR_INT_MASK: r_next.mask = wb_dat_i[NUM_EV-1:0];
            ADR_CTRL: r_next.ctrl = wb_dat_i[1:0];
            default: r_next.ctrl = r_reg.ctrl; // read-only or unmapped
          endcase
        end
      end
    end

    // readout advances only once both halves have been read
    if (rd_ack && (r_reg.cnt != 3'h0)) begin
      r_next.hi_seen = r_reg.hi_seen || (wb_sel_i[3:2] != 2'h0);
      r_next.lo_seen = r_reg.lo_seen || (wb_sel_i[1:0] != 2'h0);
      if (r_next.hi_seen && r_next.lo_seen) begin
        pop = 1'b1;
        r_next.hi_seen = 1'b0;
        r_next.lo_seen = 1'b0;
      end
    end
    if (pop) begin
      r_next.rptr = step(r_reg.rptr);
      r_next.cnt = r_reg.cnt - 3'h1;
    end

    // tracking buffer keeps the six latest entries
    if (push) begin
      r_next.abuf[r_reg.wptr] = entry;
      r_next.wptr = step(r_reg.wptr);
      ev[EV_ACK_STORED] = 1'b1;
      if (r_next.cnt == ACK_DEPTH_C) begin
        // full: drop the oldest, partial readout of it is forgotten
        r_next.rptr = step(r_next.rptr);
        r_next.hi_seen = 1'b0;
        r_next.lo_seen = 1'b0;
        ev[EV_ACK_LOST] = 1'b1;
      end else begin
        r_next.cnt = r_next.cnt + 3'h1;
      end
    end

    // formatter: host popping the offered word moves on
    if (rd_grq) begin
      r_next.have = 1'b0;
    end
    case (r_reg.st)
      BRT_IDLE: begin
        if (hdr_take) begin
          r_next.tcode = hdr_tcode_i;
          r_next.dest = hdr_dest_id_i;
          r_next.tlabel = hdr_tlabel_i;
          r_next.rt = hdr_rt_i;
          r_next.pri = hdr_priority_i;
          r_next.src = hdr_src_id_i;
          r_next.offs = hdr_offset_i;
          r_next.rcode = hdr_rcode_i;
          r_next.dlen = hdr_data_length_i;
          r_next.xtc = hdr_ext_tcode_i;
          r_next.remain = hdr_quadlet_count_i;
          if (supported) begin
            // token: complete flag, speed, count, ack sent, tcode
            r_next.word = {hdr_last_block_i, hdr_speed_i, hdr_quadlet_count_i,
                           hdr_returned_ack_code_i, 4'h0, hdr_tcode_i,
                           4'h0};
            r_next.have = 1'b1;
            r_next.st = BRT_TOKEN;
            ev[EV_TOKEN] = 1'b1;
          end else begin
            ev[EV_RX_DROP] = 1'b1;
          end
        end
      end
      BRT_TOKEN: begin
        if (rd_grq) begin
          r_next.word = {r_reg.dest, r_reg.tlabel, r_reg.rt, r_reg.tcode,
                         r_reg.pri};
          r_next.have = 1'b1;
          r_next.st = BRT_Q2;
        end
      end
      BRT_Q2: begin
        if (rd_grq) begin
          // requests carry the offset top, responses the rcode
          r_next.word = is_resp ? {r_reg.src, r_reg.rcode, 12'h0}
                                : {r_reg.src, r_reg.offs[47:32]};
          r_next.have = 1'b1;
          r_next.st = BRT_Q3;
        end
      end
      BRT_Q3: begin
        if (rd_grq) begin
          // low offset forced quadlet aligned; reserved word for responses
          r_next.word = is_resp ? 32'h0 : {r_reg.offs[31:2], 2'h0};
          r_next.have = 1'b1;
          r_next.st = BRT_Q4;
        end
      end
      BRT_Q4: begin
        if (rd_grq) begin
          r_next.word = {r_reg.dlen, r_reg.xtc};
          r_next.have = 1'b1;
          r_next.st = BRT_Q5;
        end
      end
      BRT_Q5: begin
        if (rd_grq) begin
          r_next.st = (r_reg.remain == '0) ? BRT_IDLE : BRT_PAY;
        end
      end
      BRT_PAY: begin
        // fetch one payload quadlet each time the host empties the word
        if (pay_valid_i && r_reg.pay_rdy) begin
          r_next.word = pay_data_i;
          r_next.have = 1'b1;
          r_next.remain = r_reg.remain - 1'b1;
        end else if (rd_grq && (r_reg.remain == '0)) begin
          r_next.st = BRT_IDLE;
        end
      end
      default: r_next.st = BRT_IDLE;
    endcase
    r_next.hdr_rdy = (r_next.st == BRT_IDLE) && r_next.ctrl[CTRL_RX_EN];
    r_next.pay_rdy = (r_next.st == BRT_PAY) && !r_next.have && (r_next.remain != '0);

    // sticky events: a read clears, a new event in the same cycle survives
    if (take && !wb_we_i && (wb_adr_i == ADR_INT_STATUS)) begin
      r_next.stat = '0;
    end
    r_next.stat = r_next.stat | ev;
    r_next.irq = |(r_next.stat & r_next.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.st <= BRT_IDLE;
      r_reg.ctrl <= CTRL_RESET;
      r_reg.mask <= MASK_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rdat;
  assign irq_o = r_reg.irq;
  assign hdr_ready_o = r_reg.hdr_rdy;
  assign pay_ready_o = r_reg.pay_rdy;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_bus_ack_time: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack did not follow request");
  chk_token_first: assert property ((hdr_valid_i && hdr_ready_o && supported) |=>
      (r_reg.st == BRT_TOKEN) && r_reg.have &&
      (r_reg.word[31] == $past(hdr_last_block_i)) &&
      (r_reg.word[16:12] == $past(hdr_returned_ack_code_i)))
    else $error("token not offered first");
  chk_q2_layout: assert property ((r_reg.st == BRT_Q2) |->
      (r_reg.word[31:16] == r_reg.dest) && (r_reg.word[3:0] == r_reg.pri))
    else $error("second quadlet layout wrong");
  chk_resp_reserved: assert property (((r_reg.st == BRT_Q4) && is_resp) |->
      (r_reg.word == 32'h0))
    else $error("response fourth quadlet not reserved");
  chk_offset_align: assert property (((r_reg.st == BRT_Q4) && !is_resp) |->
      (r_reg.word[1:0] == 2'h0) && (r_reg.word[31:2] == r_reg.offs[31:2]))
    else $error("offset quadlet wrong");
  chk_track_bound: assert property (r_reg.cnt <= ACK_DEPTH_C)
    else $error("tracking count above depth");
  chk_track_overwrite: assert property ((push && (r_reg.cnt == ACK_DEPTH_C) && !pop) |=>
      (r_reg.cnt == ACK_DEPTH_C) && (r_reg.rptr == r_reg.wptr))
    else $error("full buffer did not overwrite oldest");
  chk_half_read: assert property ((rd_ack && (wb_sel_i == 4'hc) && !r_reg.lo_seen &&
      !push) |=> $stable(r_reg.rptr))
    else $error("readout advanced after one half");
  chk_local_ack: assert property ((push && tx_fail_i) |=>
      (r_reg.abuf[$past(r_reg.wptr)][8:4] == $past(tx_local_ack_i)))
    else $error("failed transmit did not store local ack");
  chk_irq_level: assert property (irq_o == |(r_reg.stat & r_reg.mask))
    else $error("interrupt level disagrees with status");
  // a refused kind is taken and dropped, the formatter stays idle
  chk_drop_stays_idle: assert property ((hdr_valid_i && hdr_ready_o && !supported) |=>
      (r_reg.st == BRT_IDLE) && r_reg.stat[EV_RX_DROP])
    else $error("dropped packet left idle state");
  // token carries speed code and quadlet count as received
  chk_token_fields: assert property ((hdr_valid_i && hdr_ready_o && supported) |=>
      (r_reg.word[30:29] == $past(hdr_speed_i)) &&
      (r_reg.word[28:17] == $past(hdr_quadlet_count_i)))
    else $error("token speed or count wrong");
  // a good transmit keeps the far node's code in the entry
  chk_remote_ack: assert property ((push && !tx_fail_i) |=>
      (r_reg.abuf[$past(r_reg.wptr)][8:4] == $past(tx_remote_ack_i)))
    else $error("good transmit did not store remote ack");
  // below the depth a new entry adds one to the count
  chk_track_grow: assert property ((push && (r_reg.cnt != ACK_DEPTH_C) && !pop) |=>
      (r_reg.cnt == $past(r_reg.cnt) + 3'h1))
    else $error("tracking count did not grow");
  // an event in the cycle of a clearing read still leaves its bit set
  chk_event_sticky: assert property ((|ev) |=> ((r_reg.stat & $past(ev)) == $past(ev)))
    else $error("event lost against status read");
endmodule : brt_block_rx
`default_nettype wire

// file: verilog/brt_pkg.sv
// block receive and ack tracking: shared constants and types
// assumes a 32-bit classic wishbone host bus with byte addresses
package brt_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADR_ACK_READOUT = 8'h48; // ack tracking readout, read only
  localparam logic [7:0] ADR_GRQ_DATA = 8'h80; // general receive queue pop port
  localparam logic [7:0] ADR_STATUS = 8'h84; // queue and tracking state
  localparam logic [7:0] ADR_INT_STATUS = 8'h88; // sticky events, cleared by read
  localparam logic [7:0] ADR_INT_MASK = 8'h8c; // interrupt enables
  localparam logic [7:0] ADR_CTRL = 8'h90; // enables
  // ==========================================================
  // reset values and field positions
  localparam logic [1:0] CTRL_RESET = 2'h3; // receive and tracking enabled
  localparam int CTRL_RX_EN = 0; // accept received packets
  localparam int CTRL_TRK_EN = 1; // record transmit acknowledges
  localparam logic [3:0] MASK_RESET = 4'h0; // all interrupts masked
  localparam int EV_TOKEN = 0; // a packet token is ready in the queue
  localparam int EV_ACK_STORED = 1; // a tracking entry was written
  localparam int EV_ACK_LOST = 2; // oldest tracking entry was overwritten
  localparam int EV_RX_DROP = 3; // a non-block packet was discarded
  localparam int NUM_EV = 4;
  // ==========================================================
  // packet constants
  localparam int ACK_DEPTH = 6; // tracking entries kept
  localparam logic [2:0] ACK_DEPTH_C = 3'h6;
  localparam int QCNT_W = 12; // quadlet count width in the token
  localparam logic [3:0] TC_WR_BLOCK = 4'h1; // block write request
  localparam logic [3:0] TC_WR_RESP = 4'h2; // write response
  localparam logic [3:0] TC_RD_BLOCK = 4'h5; // block read request
  localparam logic [3:0] TC_RD_BRESP = 4'h7; // block read response
  // speed codes; 2'h3 is undefined and passed through unchanged
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;
  // retry codes
  localparam logic [1:0] RT_NEW = 2'h0;
  localparam logic [1:0] RT_RETRY_X = 2'h1;
  localparam logic [1:0] RT_RETRY_A = 2'h2;
  localparam logic [1:0] RT_RETRY_B = 2'h3;
  // response codes; 1..3 and 8..f are reserved and passed through
  localparam logic [3:0] RC_COMPLETE = 4'h0;
  localparam logic [3:0] RC_CONFLICT = 4'h4;
  localparam logic [3:0] RC_DATA_ERR = 4'h5;
  localparam logic [3:0] RC_TYPE_ERR = 4'h6;
  localparam logic [3:0] RC_ADDR_ERR = 4'h7;
  // acknowledge codes, error bit first
  localparam logic [4:0] ACK_COMPLETE = 5'h01;
  localparam logic [4:0] ACK_PENDING = 5'h02;
  localparam logic [4:0] ACK_TARDY = 5'h0b;
  localparam logic [4:0] ACK_TIMEOUT = 5'h10;
  localparam logic [4:0] ACK_PKT_ERR = 5'h13;
  // queue formatter states
  typedef enum logic [2:0] {
    BRT_IDLE, BRT_TOKEN, BRT_Q2, BRT_Q3, BRT_Q4, BRT_Q5, BRT_PAY
  } brt_state_e;
endpackage : brt_pkg

// file: verif/brt_host_model.sv
// host model: classic wishbone master that reads and writes the block
// assumes one clock shared with the block and registered slave answers
`timescale 1ns/1ps
`default_nettype none
module brt_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  // ==========================================================
  // bus idle from time zero
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  // one cycle; request held until ack is seen at a rising edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
    {wb_adr_o, wb_sel_o, wb_dat_o} <= {adr, sel, wd};
    // waits for ack at a rising edge; read data is taken at that edge
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    // released data lines no longer show the written value
    {wb_cyc_o, wb_stb_o, wb_dat_o} <= {2'b00, ~wd};
  endtask : xfer
  // readout taken as upper half then lower half, as software would
  task automatic read_entry(output logic [31:0] e);
    logic [31:0] hi;
    logic [31:0] lo;
    xfer(1'b0, 8'h48, 4'hc, 32'h0, hi);
    xfer(1'b0, 8'h48, 4'h3, 32'h0, lo);
    e = {hi[31:16], lo[15:0]};
  endtask : read_entry
endmodule : brt_host_model
`default_nettype wire

// file: verif/block_receive_and_ack_tracking_tb_top.sv
// bench: link side driven here, host model speaks wishbone to the block
// assumes brt_pkg, brt_block_rx and brt_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module block_receive_and_ack_tracking_tb_top;
  import brt_pkg::*;
  // ==========================================================
  // packet table: kinds, response codes, payload sizes
  localparam logic [15:0] DEST = 16'h2a5c;
  localparam logic [15:0] SRC = 16'hffc3;
  localparam logic [47:0] OFFS = 48'hfedc_ba98_7657;
  localparam logic [3:0] TCS [7] = '{TC_WR_BLOCK, TC_RD_BLOCK, TC_WR_RESP, TC_RD_BRESP,
                                     TC_WR_RESP, TC_RD_BRESP, TC_WR_RESP};
  localparam logic [3:0] RCS [7] = '{4'h0, 4'h0, RC_CONFLICT, RC_DATA_ERR, RC_TYPE_ERR,
                                     RC_ADDR_ERR, RC_COMPLETE};
  localparam int NQS [7] = '{2, 0, 0, 1, 0, 3, 0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, hdr_ready_o, pay_ready_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [31:0] pay_data_i = 32'h0;
  logic hdr_valid_i = 1'b0, hdr_last_block_i = 1'b0, pay_valid_i = 1'b0;
  logic tx_done_i = 1'b0, tx_fail_i = 1'b0;
  logic [3:0] hdr_tcode_i = 4'h0, hdr_rcode_i = 4'h0, tx_tcode_i = 4'h0;
  logic [15:0] hdr_dest_id_i = 16'h0, hdr_src_id_i = 16'h0;
  logic [5:0] hdr_tlabel_i = 6'h0, tx_dest_node_i = 6'h0, tx_tlabel_i = 6'h0;
  logic [1:0] hdr_rt_i = 2'h0, hdr_speed_i = 2'h0, tx_rt_i = 2'h0;
  logic [4:0] hdr_returned_ack_code_i = 5'h0, tx_remote_ack_i = 5'h0, tx_local_ack_i = 5'h0;
  logic [11:0] hdr_quadlet_count_i = 12'h0;
  logic [31:0] pay_q [$];
  int errors = 0;
  int total_checks = 0;
  // ==========================================================
  // clock, design and host
  always #2.5 clk_i = ~clk_i;
  brt_block_rx dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .hdr_valid_i, .hdr_ready_o, .hdr_tcode_i,
    .hdr_dest_id_i, .hdr_tlabel_i, .hdr_rt_i, .hdr_priority_i(4'h9), .hdr_src_id_i,
    .hdr_offset_i(OFFS), .hdr_rcode_i, .hdr_data_length_i(16'h0010),
    .hdr_ext_tcode_i(16'h00e1), .hdr_speed_i, .hdr_returned_ack_code_i, .hdr_quadlet_count_i,
    .hdr_last_block_i, .pay_valid_i, .pay_ready_o, .pay_data_i, .tx_done_i, .tx_fail_i,
    .tx_remote_ack_i, .tx_local_ack_i, .tx_dest_node_i, .tx_tlabel_i, .tx_rt_i, .tx_tcode_i);
  brt_host_model host_u (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
    .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
  // payload source: word held until taken, then the next one or idle
  always @(posedge clk_i) begin
    if (pay_valid_i && pay_ready_o) void'(pay_q.pop_front());
    pay_valid_i <= (pay_q.size() != 0);
    pay_data_i <= (pay_q.size() != 0) ? pay_q[0] : ~pay_data_i;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host_u.xfer(1'b0, a, 4'hf, 32'h0, d);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host_u.xfer(1'b1, a, 4'hf, d, x);
  endtask : wr
  // header offered and held until ready is seen at an edge
  task automatic send(input logic [3:0] tc, input int i, input logic last);
    @(posedge clk_i);
    {hdr_valid_i, hdr_tcode_i, hdr_dest_id_i, hdr_src_id_i} <= {1'b1, tc, DEST, SRC};
    {hdr_tlabel_i, hdr_rt_i, hdr_speed_i, hdr_rcode_i} <= {6'(i + 3), 2'(i), 2'(i), RCS[i]};
    hdr_returned_ack_code_i <= 5'(i + 1);
    {hdr_quadlet_count_i, hdr_last_block_i} <= {12'(NQS[i]), last};
    do begin
      @(posedge clk_i);
    end while (hdr_ready_o !== 1'b1);
    {hdr_valid_i, hdr_dest_id_i, hdr_src_id_i} <= {1'b0, ~DEST, ~SRC};
  endtask : send
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    rd(ADR_CTRL, d);
    chk("ctrl reset", 32'h3, d);
    rd(ADR_INT_MASK, d);
    chk("mask reset", 32'h0, d);
    rd(8'hfc, d);
    chk("unmapped", 32'h0, d);
    wr(ADR_ACK_READOUT, 32'hffff_ffff);
    rd(ADR_ACK_READOUT, d);
    chk("readout empty", 32'h0, d);
  endtask : t_regs
  // every block kind, speed, retry and defined response code, complete flag low once
  task automatic t_rx();
    logic [31:0] d;
    logic [31:0] w [5];
    logic resp;
    for (int i = 0; i < 7; i++) begin
      resp = (TCS[i] == TC_WR_RESP) || (TCS[i] == TC_RD_BRESP);
      w[0] = {1'(i != 2), 2'(i), 12'(NQS[i]), 5'(i + 1), 4'h0, TCS[i], 4'h0};
      w[1] = {DEST, 6'(i + 3), 2'(i), TCS[i], 4'h9};
      w[2] = resp ? {SRC, RCS[i], 12'h0} : {SRC, OFFS[47:32]};
      w[3] = resp ? 32'h0 : {OFFS[31:2], 2'b00};
      w[4] = {16'h0010, 16'h00e1};
      for (int k = 0; k < NQS[i]; k++) pay_q.push_back(32'hd000_0000 + k);
      send(TCS[i], i, 1'(i != 2));
      for (int k = 0; k < 5; k++) begin
        rd(ADR_GRQ_DATA, d);
        chk("queue word", w[k], d);
      end
      for (int k = 0; k < NQS[i]; k++) begin
        d = 32'h0;
        for (int n = 0; n < 8 && d == 32'h0; n++) rd(ADR_GRQ_DATA, d);
        chk("payload", 32'hd000_0000 + k, d);
      end
    end
    rd(ADR_GRQ_DATA, d);
    chk("empty queue", 32'h0, d);
  endtask : t_rx
  // other kinds are dropped; events masked then cleared by read
  task automatic t_drop();
    logic [31:0] d;
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd(ADR_INT_STATUS, d);
    chk("token event", 32'h1, d & 32'h1);
    send(4'h0, 0, 1'b1);
    repeat (3) @(posedge clk_i);
    chk("ready after drop", 32'h1, {31'h0, hdr_ready_o});
    rd(ADR_INT_STATUS, d);
    chk("drop event", 32'h8, d);
    rd(ADR_INT_STATUS, d);
    chk("status cleared", 32'h0, d);
    wr(ADR_CTRL, 32'h2);
    rd(ADR_CTRL, d);
    chk("ctrl written", 32'h2, d);
    chk("rx closed", 32'h0, {31'h0, hdr_ready_o});
    wr(ADR_CTRL, 32'h3);
  endtask : t_drop
  // seven transmits, one failed: six newest kept, read by halves
  task automatic t_ack();
    logic [31:0] d;
    logic [4:0] ak;
    logic [31:0] e;
    wr(ADR_INT_MASK, 32'h2);
    for (int j = 0; j < 7; j++) begin
      @(posedge clk_i);
      {tx_done_i, tx_fail_i, tx_local_ack_i} <= {1'b1, 1'(j == 3), ACK_TIMEOUT};
      tx_remote_ack_i <= ACK_COMPLETE + 5'(j & 1);
      {tx_dest_node_i, tx_tlabel_i, tx_rt_i, tx_tcode_i} <= {6'(j + 10), 6'(j), 2'(j), 4'(j)};
      @(posedge clk_i);
      tx_done_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    rd(ADR_INT_STATUS, d);
    chk("ack events", 32'h6, d);
    repeat (3) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    rd(ADR_STATUS, d);
    chk("status six held", 32'h60, d);
    for (int j = 1; j < 7; j++) begin
      ak = (j == 3) ? ACK_TIMEOUT : ACK_COMPLETE + 5'(j & 1);
      e = {6'(j + 10), 6'(j), 2'(j), 4'(j), 3'(7 - j), 2'b00, ak, 4'h0};
      host_u.read_entry(d);
      chk("ack entry", e, d);
    end
    rd(ADR_ACK_READOUT, d);
    chk("ack drained", 32'h0, d);
  endtask : t_ack
  // ==========================================================
  // verdict and run control
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_rx();
    t_drop();
    t_ack();
    end_of_test();
  end
endmodule : block_receive_and_ack_tracking_tb_top
`default_nettype wire
